// ### rtl/dar_map.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the target address and reset control bank.
 * assumes: included by bare name by the register bank module dar_regs only.
 */
`ifndef DAR_MAP_SVH
`define DAR_MAP_SVH

// register offsets on the internal register port
`define DAR_OFS_TARGET_ADDR 8'h00
`define DAR_OFS_RESET_CONTROL 8'h01
`define DAR_OFS_RESET_CAUSE 8'h0F

// target address register fields
`define DAR_ADDR_MSB 7
`define DAR_ADDR_LSB 1
`define DAR_BIT_SRC_SEL 0
`define DAR_SRC_SEL_RST 1'h0
`define DAR_ADDR_RST 7'h00

// reset control register fields
`define DAR_BIT_VID_HOLD 3
`define DAR_BIT_VID_PULSE 2
`define DAR_BIT_FULL_RST 1
`define DAR_BIT_LOGIC_RST 0
`define DAR_RESV_RST_CTL 4'h0

// reset cause status fields, clear on read
`define DAR_BIT_CAUSE_LOGIC 0
`define DAR_BIT_CAUSE_FULL 1
`define DAR_BIT_CAUSE_VID 2
`define DAR_CAUSE_RST 3'h0
`define DAR_RESV_CAUSE 5'h00

// timing: reset pulse is a least time, rounded up to whole cycles
`define DAR_CLK_PERIOD_NS 40
`define DAR_PULSE_NS 200
`define DAR_PULSE_CYCLES ((`DAR_PULSE_NS + `DAR_CLK_PERIOD_NS - 1) / `DAR_CLK_PERIOD_NS)
// strap settle: three-stage synchroniser plus one agreement cycle
`define DAR_SETTLE_CYCLES 4

`define DAR_READ_ZERO 8'h00
`define DAR_ADDR_STEP 7'h01

`endif

// ### rtl/dar_pkg.sv
/*
 * types shared by the target address and reset control bank.
 * assumes: compiled before every design module of the bank.
 */
package dar_pkg;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'h1,
        ST_LOAD = 3'h2,
        ST_RUN = 3'h4
    } dar_state_t;

    typedef logic [6:0] dar_addr_t;
    typedef logic [7:0] dar_byte_t;

endpackage

// ### rtl/dar_sync.sv
/*
 * three-stage synchroniser for strap pins; output changes only once
 * the second and third stages agree.
 * assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module dar_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // per-bit update only where stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            level_o <= '0;
        end else begin
            level_o <= (s2_reg & s3_reg) | (level_o & (s2_reg | s3_reg));
        end
    end

endmodule // dar_sync

`default_nettype wire

// ### rtl/dar_pulse.sv
/*
 * self-clearing reset pulse: a trigger starts a pulse of LEN cycles,
 * done_o marks its last cycle.
 * assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module dar_pulse #(
    parameter int LEN = 5
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic trig_i,
    output logic active_o,
    output logic done_o
);
    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);
    localparam logic [CW-1:0] ONE_C = CW'(1);

    logic [CW-1:0] cnt_reg;

    // a new trigger during a pulse restarts it, so it is never cut short
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (trig_i) begin
            cnt_reg <= LEN_C;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - ONE_C;
        end
    end

    assign active_o = (cnt_reg != '0);
    assign done_o = (cnt_reg == ONE_C) && !trig_i;

endmodule // dar_pulse

`default_nettype wire

// ### rtl/dar_regs.sv
/*
 * target address and reset control register bank: strapped target
 * address with software override, second port address, held and
 * pulsed video-input resets, two self-clearing digital resets and a
 * clear-on-read reset cause register.
 * assumes: the control-bus slave engine drives the register port on
 * sys_clk_i and uses the target address outputs for its match; strap
 * pins are asynchronous and stable around startup.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dar_map.svh"

module dar_regs #(
    parameter int PULSE_CYCLES = `DAR_PULSE_CYCLES,
    parameter int SETTLE_CYCLES = `DAR_SETTLE_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire dar_pkg::dar_byte_t reg_wdata_i,
    input wire logic reg_rd_i,
    output dar_pkg::dar_byte_t reg_rdata_o,
    output logic reg_rvalid_o,
    input wire dar_pkg::dar_addr_t address_strap_pin_i,
    input wire logic second_mode_select_pin_i,
    input wire logic second_port_bus_enable_i,
    output dar_pkg::dar_addr_t target_address_o,
    output dar_pkg::dar_addr_t second_port_target_address_o,
    output logic second_port_answer_o,
    output logic video_in_analog_reset_o,
    output logic video_in_digital_reset_o,
    output logic digital_logic_reset_o,
    output logic register_reset_o,
    output logic strap_ready_o
);
    import dar_pkg::*;

    localparam int SCW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SCW-1:0] SETTLE_C = SCW'(SETTLE_CYCLES);
    localparam logic [SCW-1:0] SONE_C = SCW'(1);

    dar_state_t state_reg;
    dar_state_t state_next;
    logic [SCW-1:0] settle_reg;

    dar_addr_t strap_addr_sync;
    logic strap_hold_sync;
    dar_addr_t strap_addr_reg;
    logic strap_hold_reg;

    dar_addr_t target_address_field_reg;
    logic address_source_select_reg;
    logic vid_hold_reg;
    logic [2:0] cause_reg;
    logic [2:0] cause_next;

    logic reg_clear;
    logic wr_addr_hit;
    logic wr_rst_hit;
    logic wr_cause_hit;
    logic rd_cause_hit;
    logic vid_trig;
    logic full_trig;
    logic logic_trig;
    logic vid_active;
    logic full_active;
    logic logic_active;
    logic full_done;
    logic vid_done;
    logic logic_done;
    dar_addr_t addr_in_use;

    dar_sync #(
        .WIDTH(7)
    ) u_addr_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(address_strap_pin_i),
        .level_o(strap_addr_sync)
    );

    dar_sync #(
        .WIDTH(1)
    ) u_mode_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(second_mode_select_pin_i),
        .level_o(strap_hold_sync)
    );

    // write decode; writes are dropped until the straps are in place
    assign wr_addr_hit = reg_wr_i && (state_reg == ST_RUN)
        && (reg_addr_i == `DAR_OFS_TARGET_ADDR);
    assign wr_rst_hit = reg_wr_i && (state_reg == ST_RUN)
        && (reg_addr_i == `DAR_OFS_RESET_CONTROL);
    assign wr_cause_hit = reg_wr_i && (state_reg == ST_RUN)
        && (reg_addr_i == `DAR_OFS_RESET_CAUSE);
    assign rd_cause_hit = reg_rd_i && (reg_addr_i == `DAR_OFS_RESET_CAUSE);

    assign vid_trig = wr_rst_hit && reg_wdata_i[`DAR_BIT_VID_PULSE];
    assign full_trig = wr_rst_hit && reg_wdata_i[`DAR_BIT_FULL_RST];
    assign logic_trig = wr_rst_hit && reg_wdata_i[`DAR_BIT_LOGIC_RST];

    dar_pulse #(
        .LEN(PULSE_CYCLES)
    ) u_vid_pulse (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(vid_trig),
        .active_o(vid_active),
        .done_o(vid_done)
    );

    dar_pulse #(
        .LEN(PULSE_CYCLES)
    ) u_full_pulse (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(full_trig),
        .active_o(full_active),
        .done_o(full_done)
    );

    dar_pulse #(
        .LEN(PULSE_CYCLES)
    ) u_logic_pulse (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(logic_trig),
        .active_o(logic_active),
        .done_o(logic_done)
    );

    // registers held at reset value while the full reset runs
    assign reg_clear = sys_rst_i || full_active;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SETTLE: begin
                if (settle_reg == SONE_C) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_next = ST_RUN;
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_SETTLE;
            end
        endcase
    end

    // strap capture restarts after a full reset, since it clears the strap registers
    always_ff @(posedge sys_clk_i) begin
        if (reg_clear) begin
            state_reg <= ST_SETTLE;
            settle_reg <= SETTLE_C;
        end else begin
            state_reg <= state_next;
            if (settle_reg != '0) begin
                settle_reg <= settle_reg - SONE_C;
            end
        end
    end

    // strap values caught once the synchronisers agree
    always_ff @(posedge sys_clk_i) begin
        if (reg_clear) begin
            strap_addr_reg <= `DAR_ADDR_RST;
            strap_hold_reg <= 1'h0;
        end else if (state_reg == ST_LOAD) begin
            strap_addr_reg <= strap_addr_sync;
            strap_hold_reg <= strap_hold_sync;
        end
    end

    // address field takes the strap, software may overwrite
    always_ff @(posedge sys_clk_i) begin
        if (reg_clear) begin
            target_address_field_reg <= `DAR_ADDR_RST;
        end else if (state_reg == ST_LOAD) begin
            target_address_field_reg <= strap_addr_sync;
        end else if (logic_trig) begin
            target_address_field_reg <= strap_addr_reg;
        end else if (wr_addr_hit) begin
            target_address_field_reg <= reg_wdata_i[`DAR_ADDR_MSB:`DAR_ADDR_LSB];
        end
    end

    // source select is plain read/write, kept by the logic reset
    always_ff @(posedge sys_clk_i) begin
        if (reg_clear) begin
            address_source_select_reg <= `DAR_SRC_SEL_RST;
        end else if (wr_addr_hit) begin
            address_source_select_reg <= reg_wdata_i[`DAR_BIT_SRC_SEL];
        end
    end

    // hold bit from mode-select strap; stays until cleared
    always_ff @(posedge sys_clk_i) begin
        if (reg_clear) begin
            vid_hold_reg <= 1'h0;
        end else if (state_reg == ST_LOAD) begin
            vid_hold_reg <= strap_hold_sync;
        end else if (logic_trig) begin
            vid_hold_reg <= strap_hold_reg;
        end else if (wr_rst_hit) begin
            vid_hold_reg <= reg_wdata_i[`DAR_BIT_VID_HOLD];
        end
    end

    // cause bits clear on read, writable; a new event beats the clear
    always_comb begin
        cause_next = cause_reg;
        if (wr_cause_hit) begin
            cause_next = reg_wdata_i[2:0];
        end else if (rd_cause_hit) begin
            cause_next = `DAR_CAUSE_RST;
        end
        if (logic_done) begin
            cause_next[`DAR_BIT_CAUSE_LOGIC] = 1'h1;
        end
        if (vid_done) begin
            cause_next[`DAR_BIT_CAUSE_VID] = 1'h1;
        end
    end

    // the full reset records itself as it lets go of the registers
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cause_reg <= `DAR_CAUSE_RST;
        end else if (full_active && !full_done) begin
            cause_reg <= `DAR_CAUSE_RST;
        end else if (full_done) begin
            cause_reg <= 3'h2;
        end else begin
            cause_reg <= cause_next;
        end
    end

    // read port: one cycle latency, unmapped offsets read zero
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `DAR_READ_ZERO;
            reg_rvalid_o <= 1'h0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `DAR_OFS_TARGET_ADDR: begin
                        reg_rdata_o <= {target_address_field_reg, address_source_select_reg};
                    end
                    `DAR_OFS_RESET_CONTROL: begin
                        // self-clearing bits show 1 only while pulsing
                        reg_rdata_o <= {`DAR_RESV_RST_CTL, vid_hold_reg, vid_active,
                            full_active, logic_active};
                    end
                    `DAR_OFS_RESET_CAUSE: begin
                        reg_rdata_o <= {`DAR_RESV_CAUSE, cause_reg};
                    end
                    default: begin
                        reg_rdata_o <= `DAR_READ_ZERO;
                    end
                endcase
            end
        end
    end

    assign addr_in_use = address_source_select_reg ? target_address_field_reg
        : strap_addr_reg;

    // second port next address; wraps above the top address
    always_ff @(posedge sys_clk_i) begin
        if (reg_clear) begin
            target_address_o <= `DAR_ADDR_RST;
            second_port_target_address_o <= `DAR_ADDR_RST;
            second_port_answer_o <= 1'h0;
        end else begin
            target_address_o <= addr_in_use;
            second_port_target_address_o <= addr_in_use + `DAR_ADDR_STEP;
            second_port_answer_o <= second_port_bus_enable_i && (state_reg == ST_RUN);
        end
    end

    // hold and pulse both reach analog and digital video input
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            video_in_analog_reset_o <= 1'h0;
            video_in_digital_reset_o <= 1'h0;
        end else begin
            video_in_analog_reset_o <= vid_hold_reg || vid_active;
            video_in_digital_reset_o <= vid_hold_reg || vid_active || logic_active
                || full_active;
        end
    end

    // digital block resets; register reset only for the full one
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            digital_logic_reset_o <= 1'h0;
            register_reset_o <= 1'h0;
            strap_ready_o <= 1'h0;
        end else begin
            digital_logic_reset_o <= logic_active || full_active;
            register_reset_o <= full_active;
            // not ready while the full reset wipes the bank, so answer and ready agree
            strap_ready_o <= (state_reg == ST_RUN) && !full_active;
        end
    end

endmodule // dar_regs

`default_nettype wire

// ### testbench/dar_regs_props.sv
/* checker for the address and reset bank: port relations over time.
   assumes: bound to dar_regs, one clock, sync active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module dar_regs_props #(
    parameter int PULSE_CYCLES = 5
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire dar_pkg::dar_byte_t reg_wdata_i,
    input wire logic reg_rd_i,
    input wire dar_pkg::dar_byte_t reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire dar_pkg::dar_addr_t address_strap_pin_i,
    input wire logic second_mode_select_pin_i,
    input wire logic second_port_bus_enable_i,
    input wire dar_pkg::dar_addr_t target_address_o,
    input wire dar_pkg::dar_addr_t second_port_target_address_o,
    input wire logic second_port_answer_o,
    input wire logic video_in_analog_reset_o,
    input wire logic video_in_digital_reset_o,
    input wire logic digital_logic_reset_o,
    input wire logic register_reset_o,
    input wire logic strap_ready_o
);
    import dar_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic ctl_wr;
    // writes count only while running; the pulse repeats assume 5 cycles
    assign ctl_wr = reg_wr_i && reg_addr_i == 8'h01 && strap_ready_o && !register_reset_o;
    property p_strap_addr;
        $rose(strap_ready_o) |=> target_address_o == address_strap_pin_i;
    endproperty
    a_strap_addr: assert property (p_strap_addr) else $error("address not strap");
    property p_second_addr;
        (strap_ready_o && $stable(target_address_o)) [*2] |->
            second_port_target_address_o == target_address_o + 7'h01;
    endproperty
    a_second_addr: assert property (p_second_addr) else $error("second address wrong");
    property p_answer;
        strap_ready_o && $past(strap_ready_o) |->
            second_port_answer_o == $past(second_port_bus_enable_i);
    endproperty
    a_answer: assert property (p_answer) else $error("second port answer wrong");
    property p_video_hold;
        video_in_analog_reset_o |-> video_in_digital_reset_o;
    endproperty
    a_video_hold: assert property (p_video_hold) else $error("video digital reset low");
    property p_full_sub;
        register_reset_o |-> digital_logic_reset_o;
    endproperty
    a_full_sub: assert property (p_full_sub) else $error("logic reset low in full");
    property p_video_pulse;
        ctl_wr && reg_wdata_i[2] |-> ##2 video_in_analog_reset_o [*5];
    endproperty
    a_video_pulse: assert property (p_video_pulse) else $error("video pulse short");
    property p_logic_pulse;
        ctl_wr && reg_wdata_i[0] && !reg_wdata_i[1] |->
            ##2 (digital_logic_reset_o && !register_reset_o) [*5] ##1 !digital_logic_reset_o;
    endproperty
    a_logic_pulse: assert property (p_logic_pulse) else $error("logic pulse wrong");
    property p_full_pulse;
        ctl_wr && reg_wdata_i[1] |-> ##2 register_reset_o [*5] ##1 !register_reset_o;
    endproperty
    a_full_pulse: assert property (p_full_pulse) else $error("full pulse wrong");
    c_video: cover property (ctl_wr && reg_wdata_i[2]);
    c_full: cover property ($fell(register_reset_o));
    c_answer: cover property (second_port_answer_o);
endmodule // dar_regs_props
bind dar_regs dar_regs_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_dar_regs_props (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .address_strap_pin_i(address_strap_pin_i),
    .second_mode_select_pin_i(second_mode_select_pin_i),
    .second_port_bus_enable_i(second_port_bus_enable_i),
    .target_address_o(target_address_o),
    .second_port_target_address_o(second_port_target_address_o),
    .second_port_answer_o(second_port_answer_o),
    .video_in_analog_reset_o(video_in_analog_reset_o),
    .video_in_digital_reset_o(video_in_digital_reset_o),
    .digital_logic_reset_o(digital_logic_reset_o),
    .register_reset_o(register_reset_o),
    .strap_ready_o(strap_ready_o)
);
`default_nettype wire

// ### testbench/dar_host.sv
/* control-bus host model: single-byte register writes and reads.
   assumes: strobes sampled on the rising edge, read data one cycle on. */
`timescale 1ns/1ps
`default_nettype none
module dar_host (
    input wire logic sys_clk_i,
    input wire dar_pkg::dar_byte_t reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output dar_pkg::dar_byte_t reg_wdata_o,
    output logic reg_rd_o
);
    import dar_pkg::*;
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input dar_byte_t d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = (a == 8'h00) ? (d & 8'hFD) : d;
        reg_wr_o = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        // released lines show junk, not the last value
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output dar_byte_t d, output logic ok);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        ok = reg_rvalid_i === 1'b1;
        d = reg_rdata_i;
    endtask
endmodule // dar_host
`default_nettype wire

// ### testbench/testbench.sv
/* self-checking bench for the address and reset bank.
   assumes: default pulse and settle counts, 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dar_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dar_row_t;
    logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, mode, en;
    logic answer, vid_a, vid_d, dig, regrst, ready;
    logic [7:0] reg_addr_i;
    dar_byte_t reg_wdata_i, reg_rdata_o;
    dar_addr_t strap, target, second;
    int n_errors = 0;
    int check_count = 0;
    dar_row_t rows [6] = '{'{8'h00, 8'h54, 8'h54}, '{8'h01, 8'h00, 8'h00},
        '{8'h01, 8'hF0, 8'h00}, '{8'h20, 8'hFF, 8'h00}, '{8'h00, 8'h55, 8'h55},
        '{8'h0F, 8'h05, 8'h05}};
    dar_regs i_dar_regs (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .address_strap_pin_i(strap), .second_mode_select_pin_i(mode),
        .second_port_bus_enable_i(en), .target_address_o(target),
        .second_port_target_address_o(second), .second_port_answer_o(answer),
        .video_in_analog_reset_o(vid_a), .video_in_digital_reset_o(vid_d),
        .digital_logic_reset_o(dig), .register_reset_o(regrst), .strap_ready_o(ready));
    dar_host i_dar_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        dar_byte_t d;
        logic ok;
        i_dar_host.rd(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask
    // bounded wait: a missing strap capture ends the run
    task automatic wait_ready;
        for (int i = 0; i < 40 && ready !== 1'b1; i++) begin
            @(negedge sys_clk_i);
        end
        if (ready !== 1'b1) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic rst_seq;
        sys_rst_i = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        wait_ready();
    endtask
    initial begin
        strap = 7'h3A;
        mode = 1'b1;
        en = 1'b1;
        rst_seq();
        chk({7'h00, vid_a}, 8'h01);
        rdc(8'h01, 8'h08);
        rdc(8'h00, 8'h74);
        @(negedge sys_clk_i);
        chk({1'b0, second}, 8'h3B);
        chk({7'h00, answer}, 8'h01);
        foreach (rows[i]) begin
            i_dar_host.wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        chk({1'b0, target}, 8'h2A);
        chk({7'h00, vid_a}, 8'h00);
        i_dar_host.wr(8'h01, 8'h04);
        repeat (2) @(negedge sys_clk_i);
        chk({6'h00, vid_a, vid_d}, 8'h03);
        repeat (5) @(negedge sys_clk_i);
        chk({7'h00, vid_a}, 8'h00);
        rdc(8'h01, 8'h00);
        rdc(8'h0F, 8'h04);
        rdc(8'h0F, 8'h00);
        i_dar_host.wr(8'h01, 8'h01);
        repeat (2) @(negedge sys_clk_i);
        chk({6'h00, dig, regrst}, 8'h02);
        repeat (5) @(negedge sys_clk_i);
        rdc(8'h00, 8'h75);
        chk({1'b0, target}, 8'h3A);
        rdc(8'h01, 8'h08);
        rdc(8'h0F, 8'h01);
        i_dar_host.wr(8'h01, 8'h02);
        // this write lands during the full reset and must be dropped
        i_dar_host.wr(8'h00, 8'h10);
        @(negedge sys_clk_i);
        chk({7'h00, regrst}, 8'h01);
        chk({7'h00, ready}, 8'h00);
        repeat (8) @(negedge sys_clk_i);
        wait_ready();
        rdc(8'h00, 8'h74);
        rdc(8'h0F, 8'h02);
        strap = 7'h10;
        mode = 1'b0;
        rst_seq();
        rdc(8'h01, 8'h00);
        rdc(8'h00, 8'h20);
        chk({1'b0, second}, 8'h11);
        en = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk({7'h00, answer}, 8'h00);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
